//--- verilog/tbcm_top.sv
// Backplane clock manager: configuration register, master generators, slave frame detect.
//
// Contract
// - Slave bit set: frame pulse and bit clock are inputs; cleared: device drives both.
// - External bit set: common clock and master timing come from the external TDM clock.
// - External bit clear in master: timing built from internal primary reference copy.
// - Format bit 0 picks generic pulse polarity: 0 active low, 1 active high.
// - Format bit 1 picks generic trigger edge: 0 falling, 1 rising.
// - Format bit 2: 0 generic, 1 serial telecom format ignoring polarity and edge.
// - After reset the configuration reads 0001: slave mode only.
`include "tbcm_consts.svh"
`default_nettype none
module tbcm_top
    import tbcm_pkg::*;
#(
    parameter int FRAME_BITS = `TBCM_FRAME_BITS,
    parameter int PRI_DIV    = `TBCM_PRI_DIV
) (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic [`TBCM_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [`TBCM_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    input  wire logic                   ext_tdm_clk,
    input  wire logic                   backplane_frame_pulse_i,
    output logic                        backplane_frame_pulse_o,
    output logic                        backplane_frame_pulse_oe_n,
    input  wire logic                   backplane_bit_clock_i,
    output logic                        backplane_bit_clock_o,
    output logic                        backplane_bit_clock_oe_n,
    output logic                        primary_reference_out,
    output logic                        common_clock_ext
);
    localparam int PW = $clog2(PRI_DIV);

    tbcm_cfg_s                cfg_r;
    logic                     aw_hold_r;
    logic                     w_hold_r;
    logic [`TBCM_ADDR_W-1:0]  awaddr_r;
    logic [31:0]              wdata_r;
    logic [3:0]               wstrb_r;
    logic                     bvalid_r;
    logic [1:0]               bresp_r;
    logic                     rvalid_r;
    logic [1:0]               rresp_r;
    logic [31:0]              rdata_r;
    logic [`TBCM_CFG_W-1:0]   cfg_nxt;
    logic                     wr_fire;
    tbcm_src_e                src;
    logic [15:0]              frame_cnt_r;
    logic [PW-1:0]            pri_cnt_r;
    logic                     primary_reference_out_r;
    logic                     primary_reference_out_d_r;
    logic                     int_tick;
    tbcm_bp_s                 int_bp;
    tbcm_bp_s                 ext_bp;
    logic                     int_act;
    logic                     int_ftick;
    logic                     ext_ftick;
    logic                     ext_tgl_l;
    logic [2:0]               ext_tgl_s;
    logic [1:0]               lrst_s;
    logic [3:0]               lcfg_s1;
    logic [3:0]               lcfg_s2;
    logic [2:0]               bclk_s;
    logic [1:0]               fp_s;
    logic                     slv_edge;
    logic                     slv_act;
    logic                     slv_prev_r;
    logic                     slv_start;
    logic                     frame_evt;

    // Source selection follows the configuration directly.
    always_comb begin
        if (cfg_r.slave) begin
            src = TBCM_SRC_SLAVE;
        end else if (cfg_r.ext_src) begin
            src = TBCM_SRC_EXT;
        end else begin
            src = TBCM_SRC_INT;
        end
    end

    // Write channel: address and data are held independently and joined here.
    assign s_axi_awready = ~aw_hold_r & ~bvalid_r;
    assign s_axi_wready  = ~w_hold_r & ~bvalid_r;
    assign wr_fire       = aw_hold_r & w_hold_r & ~bvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            awaddr_r  <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_hold_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_hold_r <= 1'b0;
            wdata_r  <= '0;
            wstrb_r  <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_hold_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_hold_r <= 1'b0;
        end
    end

    // Byte lanes 0 and 1 cover the 16-bit register; upper lanes are ignored.
    always_comb begin
        cfg_nxt = cfg_r;
        if (wstrb_r[0]) begin
            cfg_nxt[7:0] = wdata_r[7:0];
        end
        if (wstrb_r[1]) begin
            cfg_nxt[15:8] = wdata_r[15:8];
        end
    end

    // Configuration register; reset leaves the device listening to the backplane.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_r <= tbcm_cfg_s'(`TBCM_CFG_RESET);
        end else if (wr_fire && awaddr_r == `TBCM_CFG_ADDR) begin
            cfg_r <= tbcm_cfg_s'(cfg_nxt);
        end
    end

    // Write response; the status word is read-only, so a write to it is accepted and dropped.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r  <= `TBCM_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r  <= (awaddr_r == `TBCM_CFG_ADDR || awaddr_r == `TBCM_STAT_ADDR) ?
                        `TBCM_RESP_OKAY : `TBCM_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // Read channel answers one cycle after the address is taken.
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= '0;
            rresp_r  <= `TBCM_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_r <= 1'b1;
            rresp_r  <= `TBCM_RESP_OKAY;
            if (s_axi_araddr == `TBCM_CFG_ADDR) begin
                rdata_r <= {16'h0000, cfg_r};
            end else if (s_axi_araddr == `TBCM_STAT_ADDR) begin
                rdata_r <= {frame_cnt_r, 13'h0000, src};
            end else begin
                rdata_r <= '0;
                rresp_r <= `TBCM_RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // Primary reference divider; its internal copy paces the internal generator.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pri_cnt_r   <= '0;
            primary_reference_out_r   <= 1'b0;
            primary_reference_out_d_r <= 1'b0;
        end else begin
            pri_cnt_r   <= (pri_cnt_r == PW'(PRI_DIV - 1)) ? '0 : pri_cnt_r + 1'b1;
            primary_reference_out_r   <= (pri_cnt_r == PW'(PRI_DIV - 1)) ? ~primary_reference_out_r : primary_reference_out_r;
            primary_reference_out_d_r <= primary_reference_out_r;
        end
    end

    assign primary_reference_out = primary_reference_out_r;
    assign int_tick              = primary_reference_out_r ^ primary_reference_out_d_r;

    tbcm_fp_gen #(
        .FRAME_BITS (FRAME_BITS)
    ) u_int_gen (
        .clk        (aclk),
        .rst_n      (aresetn),
        .run        (src == TBCM_SRC_INT),
        .tick       (int_tick),
        .stbus_fmt  (cfg_r.stbus_fmt),
        .pol_high   (cfg_r.pol_high),
        .edge_rise  (cfg_r.edge_rise),
        .bp         (int_bp),
        .frame_act  (int_act),
        .frame_tick (int_ftick)
    );

    // Link domain: reset and quasi-static configuration pass two flip-flops.
    always_ff @(posedge ext_tdm_clk) begin
        lrst_s  <= {lrst_s[0], aresetn};
        lcfg_s1 <= {src == TBCM_SRC_EXT, cfg_r.stbus_fmt, cfg_r.pol_high, cfg_r.edge_rise};
        lcfg_s2 <= lcfg_s1;
    end

    // External pin paces the link-side generator directly, one tick per link clock.
    tbcm_fp_gen #(
        .FRAME_BITS (FRAME_BITS)
    ) u_ext_gen (
        .clk        (ext_tdm_clk),
        .rst_n      (lrst_s[1]),
        .run        (lcfg_s2[3]),
        .tick       (1'b1),
        .stbus_fmt  (lcfg_s2[2]),
        .pol_high   (lcfg_s2[1]),
        .edge_rise  (lcfg_s2[0]),
        .bp         (ext_bp),
        .frame_act  (),
        .frame_tick (ext_ftick)
    );

    // Frame events leave the link domain as a toggle.
    always_ff @(posedge ext_tdm_clk) begin
        if (!lrst_s[1]) begin
            ext_tgl_l <= 1'b0;
        end else if (ext_ftick) begin
            ext_tgl_l <= ~ext_tgl_l;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_tgl_s <= '0;
        end else begin
            ext_tgl_s <= {ext_tgl_s[1:0], ext_tgl_l};
        end
    end

    // Pin drive: the enables are low only in master mode.
    assign common_clock_ext           = cfg_r.ext_src;
    assign backplane_bit_clock_oe_n   = cfg_r.slave;
    assign backplane_frame_pulse_oe_n = cfg_r.slave;
    assign backplane_bit_clock_o      = cfg_r.ext_src ? ext_bp.bit_clock : int_bp.bit_clock;
    assign backplane_frame_pulse_o    = cfg_r.ext_src ? ext_bp.frame_pulse : int_bp.frame_pulse;

    // Incoming pins pass two flip-flops; the third bit-clock stage is only for edge detect.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bclk_s <= '0;
            fp_s   <= '0;
        end else begin
            bclk_s <= {bclk_s[1:0], backplane_bit_clock_i};
            fp_s   <= {fp_s[0], backplane_frame_pulse_i};
        end
    end

    // Slave detect uses the same format, edge and polarity as master generation.
    always_comb begin
        if (cfg_r.stbus_fmt) begin
            slv_edge = ~bclk_s[1] & bclk_s[2];
            slv_act  = ~fp_s[1];
        end else begin
            slv_edge = cfg_r.edge_rise ? (bclk_s[1] & ~bclk_s[2]) : (~bclk_s[1] & bclk_s[2]);
            slv_act  = cfg_r.pol_high ? fp_s[1] : ~fp_s[1];
        end
        slv_start = (src == TBCM_SRC_SLAVE) & slv_edge & slv_act & ~slv_prev_r;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || src != TBCM_SRC_SLAVE) begin
            slv_prev_r <= 1'b0;
        end else if (slv_edge) begin
            slv_prev_r <= slv_act;
        end
    end

    // Frame counter counts whichever source is active; it wraps silently.
    assign frame_evt = slv_start | int_ftick | ((src == TBCM_SRC_EXT) & (ext_tgl_s[2] ^ ext_tgl_s[1]));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            frame_cnt_r <= '0;
        end else if (frame_evt) begin
            frame_cnt_r <= frame_cnt_r + 1'b1;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_reset_slave_value: assert property (
        !$past(aresetn) |-> cfg_r == tbcm_cfg_s'(`TBCM_CFG_RESET) && backplane_bit_clock_oe_n)
        else $error("configuration not at reset value after reset");
    chk_slave_pins_released: assert property (
        wr_fire && awaddr_r == `TBCM_CFG_ADDR && wstrb_r[0]
        |=> (backplane_frame_pulse_oe_n == $past(wdata_r[0])) && (backplane_bit_clock_oe_n == $past(wdata_r[0])))
        else $error("pin drive does not follow slave bit");
    chk_ext_source_out: assert property (
        !cfg_r.slave && cfg_r.ext_src |-> backplane_bit_clock_o == ext_bp.bit_clock && common_clock_ext)
        else $error("external source not routed to bit clock");
    chk_int_ref_pace: assert property (
        src == TBCM_SRC_INT && $stable(cfg_r) && !int_tick |=> $stable(int_bp.bit_clock))
        else $error("internal bit clock moved without reference edge");
    chk_generic_polarity: assert property (
        src == TBCM_SRC_INT && !cfg_r.stbus_fmt && $stable(cfg_r) && $past(src) == TBCM_SRC_INT
        |-> backplane_frame_pulse_o == (cfg_r.pol_high ? int_act : !int_act))
        else $error("generic frame pulse polarity wrong");
    chk_generic_edge: assert property (
        src == TBCM_SRC_INT && !cfg_r.stbus_fmt && $stable(cfg_r) && $changed(int_act)
        |-> int_bp.bit_clock == cfg_r.edge_rise)
        else $error("generic frame pulse on wrong edge");
    chk_stbus_format: assert property (
        src == TBCM_SRC_INT && cfg_r.stbus_fmt && $stable(cfg_r) && $past(src) == TBCM_SRC_INT
        |-> backplane_frame_pulse_o == !int_act && (!$changed(int_act) || !int_bp.bit_clock))
        else $error("serial telecom frame pulse wrong");
    chk_slave_frame_count: assert property (
        slv_start |=> frame_cnt_r == $past(frame_cnt_r) + 16'h0001)
        else $error("slave frame start not counted");
    chk_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");

    cov_master_int: cover property (src == TBCM_SRC_INT ##1 int_ftick);
    cov_master_ext: cover property (src == TBCM_SRC_EXT && frame_evt);
    cov_slave_frame: cover property (slv_start);
    cov_stbus_slave: cover property (cfg_r.stbus_fmt && slv_start);

endmodule
`default_nettype wire

//--- common/tbcm_consts.svh
// Address map, field layout, reset values and sizes for the backplane clock manager.
`ifndef TBCM_CONSTS_SVH
`define TBCM_CONSTS_SVH

`define TBCM_ADDR_W        16
`define TBCM_CFG_ADDR      16'h5000
`define TBCM_STAT_ADDR     16'h5004
`define TBCM_CFG_W         16
`define TBCM_CFG_RESET     16'h0001
`define TBCM_CFG_FMT_LSB   2
`define TBCM_CFG_FMT_MSB   4
`define TBCM_STAT_CNT_LSB  16
`define TBCM_FRAME_BITS    256
`define TBCM_PRI_DIV       4
`define TBCM_RESP_OKAY     2'b00
`define TBCM_RESP_SLVERR   2'b10

`endif

//--- common/tbcm_pkg.sv
// Types shared by the backplane clock manager modules.
`default_nettype none
package tbcm_pkg;

    // Configuration word, bit 0 at the bottom.
    typedef struct packed {
        logic [10:0] other;
        logic        stbus_fmt;
        logic        edge_rise;
        logic        pol_high;
        logic        ext_src;
        logic        slave;
    } tbcm_cfg_s;

    // Backplane timing pair driven by a generator.
    typedef struct packed {
        logic frame_pulse;
        logic bit_clock;
    } tbcm_bp_s;

    // Timing source the block currently uses.
    typedef enum logic [2:0] {
        TBCM_SRC_SLAVE = 3'b001,
        TBCM_SRC_INT   = 3'b010,
        TBCM_SRC_EXT   = 3'b100
    } tbcm_src_e;

endpackage
`default_nettype wire

//--- verilog/tbcm_fp_gen.sv
// Frame pulse and bit clock generator, advanced by a tick in its own clock domain.
`include "tbcm_consts.svh"
`default_nettype none
module tbcm_fp_gen
    import tbcm_pkg::*;
#(
    parameter int FRAME_BITS = `TBCM_FRAME_BITS
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic run,
    input  wire logic tick,
    input  wire logic stbus_fmt,
    input  wire logic pol_high,
    input  wire logic edge_rise,
    output tbcm_bp_s  bp,
    output logic      frame_act,
    output logic      frame_tick
);
    localparam int CW = $clog2(FRAME_BITS);

    logic [CW-1:0] bit_cnt_r;
    logic          bclk_r;
    logic          act_r;
    logic          fp_r;
    logic          tick_r;
    logic          trig;
    logic          act_nxt;
    logic [CW-1:0] cnt_nxt;

    // Serial telecom format always steps on the falling bit clock edge.
    always_comb begin
        trig    = tick & (stbus_fmt ? bclk_r : (edge_rise ? ~bclk_r : bclk_r));
        cnt_nxt = (bit_cnt_r == CW'(FRAME_BITS - 1)) ? '0 : bit_cnt_r + 1'b1;
        act_nxt = trig ? (cnt_nxt == '0) : act_r;
    end

    // Bit clock toggles on every tick; the frame counter moves on the trigger edge.
    always_ff @(posedge clk) begin
        if (!rst_n || !run) begin
            bclk_r    <= 1'b0;
            bit_cnt_r <= '0;
            act_r     <= 1'b0;
            tick_r    <= 1'b0;
        end else begin
            if (tick) begin
                bclk_r <= ~bclk_r;
            end
            if (trig) begin
                bit_cnt_r <= cnt_nxt;
            end
            act_r  <= act_nxt;
            tick_r <= act_nxt & ~act_r;
        end
    end

    // Pin level: serial telecom is active low, generic follows the polarity bit.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fp_r <= 1'b1;
        end else begin
            fp_r <= stbus_fmt ? ~act_nxt : (pol_high ? act_nxt : ~act_nxt);
        end
    end

    assign bp.bit_clock   = bclk_r;
    assign bp.frame_pulse = fp_r;
    assign frame_act      = act_r;
    assign frame_tick     = tick_r;

endmodule
`default_nettype wire

//--- sim/tbcm_bp_model.sv
// Backplane partner: free-running bit clock, framed pulse source and pin resolution.
`default_nettype none
module tbcm_bp_model #(
    parameter int FRAME_BITS = 8,
    parameter int HALF       = 3
) (
    input  wire logic clk,
    input  wire logic run,
    input  wire logic pol_high,
    input  wire logic edge_rise,
    input  wire logic stbus_fmt,
    input  wire logic dev_fp_o,
    input  wire logic dev_fp_oe_n,
    input  wire logic dev_bc_o,
    input  wire logic dev_bc_oe_n,
    output logic      fp_wire,
    output logic      bc_wire,
    output int        frames_sent
);
    timeunit 1ns;
    timeprecision 1ps;
    logic bc_r    = 1'b0;
    logic fp_r    = 1'b1;
    int   ph      = 0;
    int   bit_idx = 0;
    int   cnt     = 0;
    logic samp_lvl;
    logic act_lvl;
    logic fire;
    // Telecom format forces a low pulse sampled on the falling edge.
    assign samp_lvl = stbus_fmt ? 1'b0 : edge_rise;
    assign act_lvl  = stbus_fmt ? 1'b0 : pol_high;
    assign fire     = (bit_idx == FRAME_BITS - 1) && run;
    // The pulse moves on the unsampled edge, so it is stable when the device samples.
    always @(posedge clk) begin
        if (ph == HALF - 1) begin
            ph <= 0;
            bc_r <= ~bc_r;
            if (bc_r == samp_lvl) begin
                bit_idx <= (bit_idx + 1) % FRAME_BITS;
                fp_r <= fire ? act_lvl : ~act_lvl;
                cnt <= cnt + (fire ? 1 : 0);
            end
        end else begin
            ph <= ph + 1;
        end
    end
    // The device wins whenever it enables its drivers.
    assign fp_wire     = dev_fp_oe_n ? fp_r : dev_fp_o;
    assign bc_wire     = dev_bc_oe_n ? bc_r : dev_bc_o;
    assign frames_sent = cnt;
endmodule
`default_nettype wire

//--- sim/tb_tbcm_top.sv
// Self-checking bench for the backplane clock manager.
`include "tbcm_consts.svh"
`default_nettype none
module tb_tbcm_top
    import tbcm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int FB  = 8;
    localparam int PD  = 4;
    localparam int WIN = 4 * FB * PD;
    localparam logic [2:0] FMT [5] = '{3'b000, 3'b001, 3'b010, 3'b011, 3'b111};
    logic        aclk    = 1'b0;
    logic        ext_clk = 1'b0;
    logic        aresetn = 1'b0;
    logic [15:0] awaddr = 16'h0, araddr = 16'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  wstrb = 4'hf;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic        fp_o, fp_oe_n, bc_o, bc_oe_n, pri, cce, fp_w, bc_w;
    logic        m_run = 1'b0, m_pol = 1'b0, m_edge = 1'b0, m_st = 1'b0;
    int          frames;
    int          n_mismatch      = 0;
    int          samples_checked = 0;
    int          bc_n = 0, fp_n = 0, pr_n = 0;
    // The link clock starts off-phase so the two domains never line up.
    initial begin
        forever #12.5 aclk = ~aclk;
    end
    initial begin
        #3.1;
        forever #7.5 ext_clk = ~ext_clk;
    end
    // Pin edge counters measure rates with no alignment to aclk.
    always @(bc_o) bc_n++;
    always @(fp_o) fp_n++;
    always @(pri) pr_n++;
    tbcm_top #(.FRAME_BITS(FB), .PRI_DIV(PD)) DUT (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_tdm_clk(ext_clk),
        .backplane_frame_pulse_i(fp_w), .backplane_frame_pulse_o(fp_o),
        .backplane_frame_pulse_oe_n(fp_oe_n), .backplane_bit_clock_i(bc_w),
        .backplane_bit_clock_o(bc_o), .backplane_bit_clock_oe_n(bc_oe_n),
        .primary_reference_out(pri), .common_clock_ext(cce));
    tbcm_bp_model #(.FRAME_BITS(FB), .HALF(3)) PARTNER (
        .clk(aclk), .run(m_run), .pol_high(m_pol), .edge_rise(m_edge),
        .stbus_fmt(m_st), .dev_fp_o(fp_o), .dev_fp_oe_n(fp_oe_n), .dev_bc_o(bc_o),
        .dev_bc_oe_n(bc_oe_n), .fp_wire(fp_w), .bc_wire(bc_w), .frames_sent(frames));
    task automatic finish_test();
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
        samples_checked++;
        if (g < lo || g > hi) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask
    // A hung handshake counts as a mismatch and ends the run.
    task automatic bound(inout int n);
        n++;
        if (n > 500) begin
            n_mismatch++;
            $display("CHECK FAILED handshake expected answer seen none");
            finish_test();
        end
    endtask
    // Ready is read at the falling edge; it shows what the next rising edge takes.
    task automatic axi_wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
        logic       ha, hw, hs;
        logic [1:0] r;
        int         n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(negedge aclk);
            ha = awvalid && awready;
            hw = wvalid && wready;
            @(posedge aclk);
            awvalid <= awvalid && !ha;
            wvalid <= wvalid && !hw;
            bound(n);
        end while ((awvalid && !ha) || (wvalid && !hw));
        bready <= 1'b1;
        do begin
            @(negedge aclk);
            hs = bvalid;
            r = bresp;
            @(posedge aclk);
            bound(n);
        end while (!hs);
        bready <= 1'b0;
        chk("bresp", 32'(er), 32'(r));
    endtask
    task automatic axi_rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
        logic hs;
        int   n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(negedge aclk);
            hs = arready;
            @(posedge aclk);
            bound(n);
        end while (!hs);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do begin
            @(negedge aclk);
            {hs, d, r} = {rvalid, rdata, rresp};
            @(posedge aclk);
            bound(n);
        end while (!hs);
        rready <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] m, input logic [31:0] e,
                      input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(a, d, r);
        chk("rresp", 32'(er), 32'(r));
        chk("rdata", e, d & m);
    endtask
    // Pins are looked at on the falling edge, then the bench returns to the rising edge.
    task automatic chk_pins(input logic oe_n, input logic ext);
        @(negedge aclk);
        chk("fp_oe_n", 32'(oe_n), 32'(fp_oe_n));
        chk("bc_oe_n", 32'(oe_n), 32'(bc_oe_n));
        chk("common_clock_ext", 32'(ext), 32'(cce));
        @(posedge aclk);
    endtask
    // Slave: frames sent by the backplane must all be counted by the detector.
    task automatic slave_run(input logic [2:0] f);
        logic [31:0] d0, d1;
        logic [1:0]  r;
        int          f0;
        m_pol <= f[0];
        m_edge <= f[1];
        m_st <= f[2];
        axi_wr(`TBCM_CFG_ADDR, {27'h0, f, 2'b01}, `TBCM_RESP_OKAY);
        repeat (60) @(posedge aclk);
        chk_pins(1'b1, 1'b0);
        axi_rd(`TBCM_STAT_ADDR, d0, r);
        f0 = frames;
        m_run <= 1'b1;
        repeat (8 * FB * 6) @(posedge aclk);
        m_run <= 1'b0;
        repeat (60) @(posedge aclk);
        axi_rd(`TBCM_STAT_ADDR, d1, r);
        chk("slave src", TBCM_SRC_SLAVE, {29'h0, d1[2:0]});
        chk("frame count", frames - f0, {16'h0, 16'(d1[31:16] - d0[31:16])});
    endtask
    // Master: pulse level, width and rate; alignment to the chosen bit clock edge is checked with the internal source only.
    task automatic master_run(input logic [2:0] f, input logic ext);
        logic act, smp, lastfp;
        int   b0, p0, q0, na, nbad;
        act = f[2] ? 1'b0 : f[0];
        smp = f[2] ? 1'b0 : f[1];
        axi_wr(`TBCM_CFG_ADDR, {27'h0, f, ext, 1'b0}, `TBCM_RESP_OKAY);
        repeat (200) @(posedge aclk);
        rd(`TBCM_STAT_ADDR, 32'h7, ext ? TBCM_SRC_EXT : TBCM_SRC_INT, `TBCM_RESP_OKAY);
        chk_pins(1'b0, ext);
        @(negedge aclk);
        b0 = bc_n;
        p0 = fp_n;
        q0 = pr_n;
        na = 0;
        nbad = 0;
        lastfp = fp_o;
        repeat (WIN) begin
            @(negedge aclk);
            na += (fp_o === act) ? 1 : 0;
            nbad += (fp_o !== lastfp && bc_o !== smp) ? 1 : 0;
            lastfp = fp_o;
        end
        @(posedge aclk);
        if (ext) begin
            chk_rng("bc toggles", WIN * 25 / 15 - 2, WIN * 25 / 15 + 2, bc_n - b0);
            chk_rng("fp edges", 2 * WIN * 25 / (FB * 30) - 3, 2 * WIN * 25 / (FB * 30) + 3,
                    fp_n - p0);
            chk_rng("fp active", WIN / FB - 6, WIN / FB + 6, na);
        end else begin
            chk("bc toggles", 4 * FB, bc_n - b0);
            chk("pri toggles", 4 * FB, pr_n - q0);
            chk("fp edges", 4, fp_n - p0);
            chk("fp active", 4 * PD, na);
            chk("fp edge align", 0, nbad);
        end
    endtask
    // Reset values, register access, then every format in all three modes.
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        chk_pins(1'b1, 1'b0);
        rd(`TBCM_CFG_ADDR, 32'hffffffff, `TBCM_CFG_RESET, `TBCM_RESP_OKAY);
        rd(`TBCM_STAT_ADDR, 32'h7, TBCM_SRC_SLAVE, `TBCM_RESP_OKAY);
        axi_wr(`TBCM_CFG_ADDR, 32'hffffffe1, `TBCM_RESP_OKAY);
        rd(`TBCM_CFG_ADDR, 32'hffffffff, 32'h0000ffe1, `TBCM_RESP_OKAY);
        axi_wr(16'h5008, 32'h0, `TBCM_RESP_SLVERR);
        rd(16'h5008, 32'hffffffff, 32'h0, `TBCM_RESP_SLVERR);
        axi_wr(`TBCM_STAT_ADDR, 32'h0, `TBCM_RESP_OKAY);
        rd(`TBCM_CFG_ADDR, 32'hffffffff, 32'h0000ffe1, `TBCM_RESP_OKAY);
        foreach (FMT[i]) slave_run(FMT[i]);
        foreach (FMT[i]) master_run(FMT[i], 1'b0);
        foreach (FMT[i]) master_run(FMT[i], 1'b1);
        axi_wr(`TBCM_CFG_ADDR, 32'h1, `TBCM_RESP_OKAY);
        chk_pins(1'b1, 1'b0);
        axi_wr(`TBCM_CFG_ADDR, 32'h12, `TBCM_RESP_OKAY);
        aresetn <= 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        chk_pins(1'b1, 1'b0);
        rd(`TBCM_CFG_ADDR, 32'hffffffff, `TBCM_CFG_RESET, `TBCM_RESP_OKAY);
        finish_test();
    end
endmodule
`default_nettype wire
